// file: rtl/link_regs_cfg.svh
// constants of the port link control and status dword
`ifndef LINK_REGS_CFG_SVH
`define LINK_REGS_CFG_SVH
`define LNK_OFFSET 32'h0000_00D0
`define ASPM_LSB 0
`define ASPM_MSB 1
`define CMPL_BND_BIT 3
`define DIS_BIT 4
`define RTR_BIT 5
`define CCLK_BIT 6
`define ESYN_BIT 7
`define CPM_BIT 8
`define AWD_BIT 9
`define BWIE_BIT 10
`define ABIE_BIT 11
`define SPD_LSB 16
`define SPD_MSB 19
`define WID_LSB 20
`define WID_MSB 25
`define TERR_BIT 26
`define TRN_BIT 27
`define SCLK_BIT 28
`define DLA_BIT 29
`define BWS_BIT 30
`define ABS_BIT 31
`define SPD_RST 4'h2
`define SPD_MAX 4'h2
`define SPD_MIN 4'h1
`define WID_RST 6'h01
`define EXT_FTS 13'h1000
`define EXT_TS1 13'h0400
`define NRM_FTS 13'h00FF
`define NRM_TS1 13'h0010
`endif

// file: rtl/link_regs_pkg.sv
// types of the port link control and status dword
package link_regs_pkg;
  typedef enum logic [1:0] {DP_IDLE, DP_WRITE} dphase_type;
  typedef logic [3:0] speed_type;
  typedef logic [5:0] width_type;
endpackage

// file: rtl/pcie_port_link_ctrl_status.sv
// link control and status register pair of one switch port
//
// Design decision made here: the AHB-Lite interface to the registers.
`include "link_regs_cfg.svh"
module pcie_port_link_ctrl_status
(
  input  wire logic                   clk_i,
  input  wire logic                   arst_n_i,
  input  wire logic                   ce_i,
  input  wire logic                   hsel_i,
  input  wire logic [31:0]            haddr_i,
  input  wire logic [1:0]             htrans_i,
  input  wire logic                   hwrite_i,
  input  wire logic [2:0]             hsize_i,
  input  wire logic [31:0]            hwdata_i,
  input  wire logic                   hready_i,
  output logic                        hreadyout_o,
  output logic                        hresp_o,
  output logic [31:0]                 hrdata_o,
  input  wire logic                   upstream_port_i,
  input  wire link_regs_pkg::speed_type link_speed_i,
  input  wire link_regs_pkg::width_type link_width_i,
  input  wire logic                   train_start_i,
  input  wire logic                   train_done_i,
  input  wire logic                   train_fail_i,
  input  wire logic                   dl_active_i,
  input  wire logic                   slot_clk_load_i,
  input  wire logic                   slot_clk_val_i,
  input  wire logic                   bw_mgmt_evt_i,
  input  wire logic                   bw_auto_evt_i,
  input  wire logic                   clk_need_i,
  output logic                        l0s_en_o,
  output logic                        l1_en_o,
  output logic                        rx_l0s_ok_o,
  output logic                        link_disable_o,
  output logic                        retrain_o,
  output logic                        common_clk_o,
  output logic [12:0]                 fts_count_o,
  output logic [12:0]                 ts1_count_o,
  output logic                        clkreq_n_o,
  output logic                        hw_width_dis_o,
  output logic                        bw_irq_o
);
  import link_regs_pkg::*;

  dphase_type  dph_q;
  logic        sel_ok;
  logic        wr_en;
  logic [31:0] rd_word;
  logic [1:0]  aspm_q;
  logic        dis_q;
  logic        cclk_q;
  logic        esyn_q;
  logic        cpm_q;
  logic        awd_q;
  logic        bwie_q;
  logic        abie_q;
  speed_type   spd_q;
  width_type   wid_q;
  logic        terr_q;
  logic        trn_q;
  logic        sclk_q;
  logic        dla_q;
  logic        bws_q;
  logic        abs_q;

  // address phase decode
  assign sel_ok = hsel_i && hready_i && htrans_i[1]
                  && (haddr_i == `LNK_OFFSET);
  assign wr_en  = ce_i && (dph_q == DP_WRITE);

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      dph_q <= DP_IDLE;
    else if (ce_i && hready_i)
    begin
      case (dph_q)
        DP_IDLE:  dph_q <= (sel_ok && hwrite_i) ? DP_WRITE : DP_IDLE;
        DP_WRITE: dph_q <= (sel_ok && hwrite_i) ? DP_WRITE : DP_IDLE;
        default:  dph_q <= DP_IDLE;
      endcase
    end
  end

  // read image of the dword
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_word[`ASPM_MSB:`ASPM_LSB] = aspm_q;
    rd_word[`CMPL_BND_BIT] = 1'b0;
    rd_word[`DIS_BIT]  = dis_q;
    rd_word[`RTR_BIT]  = 1'b0;
    rd_word[`CCLK_BIT] = cclk_q;
    rd_word[`ESYN_BIT] = esyn_q;
    rd_word[`CPM_BIT]  = cpm_q;
    rd_word[`AWD_BIT]  = awd_q;
    rd_word[`BWIE_BIT] = bwie_q;
    rd_word[`ABIE_BIT] = abie_q;
    rd_word[`SPD_MSB:`SPD_LSB] = spd_q;
    rd_word[`WID_MSB:`WID_LSB] = wid_q;
    rd_word[`TERR_BIT] = terr_q;
    rd_word[`TRN_BIT]  = trn_q;
    rd_word[`SCLK_BIT] = sclk_q;
    rd_word[`DLA_BIT]  = dla_q;
    rd_word[`BWS_BIT]  = bws_q;
    rd_word[`ABS_BIT]  = abs_q;
  end

  // bus answer, zero wait, always okay
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      hrdata_o    <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (hready_i)
        hrdata_o <= (sel_ok && !hwrite_i) ? rd_word : 32'h0000_0000;
    end
  end

  // control half
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      aspm_q <= 2'h0;
      cclk_q <= 1'b0;
      esyn_q <= 1'b0;
      awd_q  <= 1'b0;
    end
    else if (wr_en)
    begin
      aspm_q <= hwdata_i[`ASPM_MSB:`ASPM_LSB];
      cclk_q <= hwdata_i[`CCLK_BIT];
      esyn_q <= hwdata_i[`ESYN_BIT];
      awd_q  <= hwdata_i[`AWD_BIT];
    end
  end

  // port-role dependent control bits
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dis_q  <= 1'b0;
      cpm_q  <= 1'b0;
      bwie_q <= 1'b0;
      abie_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (upstream_port_i)
      begin
        dis_q  <= 1'b0;
        bwie_q <= 1'b0;
        abie_q <= 1'b0;
        if (wr_en)
          cpm_q <= hwdata_i[`CPM_BIT];
      end
      else
      begin
        cpm_q <= 1'b0;
        if (wr_en)
        begin
          dis_q  <= hwdata_i[`DIS_BIT];
          bwie_q <= hwdata_i[`BWIE_BIT];
          abie_q <= hwdata_i[`ABIE_BIT];
        end
      end
    end
  end

  // negotiated speed and width
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      spd_q <= `SPD_RST;
      wid_q <= `WID_RST;
    end
    else if (ce_i && train_done_i)
    begin
      if (link_speed_i >= `SPD_MIN && link_speed_i <= `SPD_MAX)
        spd_q <= link_speed_i;
      wid_q <= link_width_i;
    end
  end

  // training progress and error
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      terr_q <= 1'b0;
      trn_q  <= 1'b1;
    end
    else if (ce_i)
    begin
      if (train_fail_i)
        terr_q <= 1'b1;
      else if (train_done_i)
        terr_q <= 1'b0;
      if (train_start_i)
        trn_q <= 1'b1;
      else if (train_done_i || train_fail_i)
        trn_q <= 1'b0;
    end
  end

  // slot clock and data link state
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sclk_q <= 1'b1;
      dla_q  <= 1'b0;
    end
    else if (ce_i)
    begin
      if (slot_clk_load_i)
        sclk_q <= slot_clk_val_i;
      dla_q <= dl_active_i;
    end
  end

  // bandwidth flags, set wins over clear
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      bws_q <= 1'b0;
      abs_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (bw_mgmt_evt_i)
        bws_q <= 1'b1;
      else if (wr_en && hwdata_i[`BWS_BIT])
        bws_q <= 1'b0;
      if (bw_auto_evt_i)
        abs_q <= 1'b1;
      else if (wr_en && hwdata_i[`ABS_BIT])
        abs_q <= 1'b0;
    end
  end

  // registered outputs toward the link
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      l0s_en_o       <= 1'b0;
      l1_en_o        <= 1'b0;
      rx_l0s_ok_o    <= 1'b1;
      link_disable_o <= 1'b0;
      retrain_o      <= 1'b0;
      common_clk_o   <= 1'b0;
      fts_count_o    <= `NRM_FTS;
      ts1_count_o    <= `NRM_TS1;
      clkreq_n_o     <= 1'b0;
      hw_width_dis_o <= 1'b0;
      bw_irq_o       <= 1'b0;
    end
    else if (ce_i)
    begin
      l0s_en_o       <= aspm_q[0];
      l1_en_o        <= aspm_q[1];
      rx_l0s_ok_o    <= 1'b1;
      link_disable_o <= dis_q && !upstream_port_i;
      retrain_o      <= wr_en && hwdata_i[`RTR_BIT]
                        && !upstream_port_i;
      common_clk_o   <= cclk_q;
      fts_count_o    <= esyn_q ? `EXT_FTS : `NRM_FTS;
      ts1_count_o    <= esyn_q ? `EXT_TS1 : `NRM_TS1;
      clkreq_n_o     <= cpm_q ? !clk_need_i : 1'b0;
      hw_width_dis_o <= awd_q;
      bw_irq_o       <= (bws_q && bwie_q)
                        || (abs_q && abie_q);
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_aspm_decode: assert property (
    (ce_i && aspm_q == 2'h1) |=> (l0s_en_o && !l1_en_o))
    else $error("standby-only setting not decoded");
  a_rx_standby_ok: assert property (
    rx_l0s_ok_o)
    else $error("receiver standby entry blocked");
  a_ro_bits_zero: assert property (
    !hrdata_o[`CMPL_BND_BIT] && !hrdata_o[`RTR_BIT])
    else $error("read-only zero bit read as one");
  a_up_no_disable: assert property (
    (ce_i && upstream_port_i) |=> !link_disable_o)
    else $error("upstream link disabled");
  a_retrain_cause: assert property (
    retrain_o |-> ($past(wr_en) && !$past(upstream_port_i)))
    else $error("retrain pulse without downstream write");
  a_ext_sync_cnt: assert property (
    (ce_i && esyn_q) |=>
      (fts_count_o == `EXT_FTS && ts1_count_o == `EXT_TS1))
    else $error("extended sync counts wrong");
  a_clkreq_held: assert property (
    (ce_i && !cpm_q) |=> !clkreq_n_o)
    else $error("clock request released while disabled");
  a_dn_cpm_zero: assert property (
    (ce_i && !upstream_port_i) |=> !cpm_q)
    else $error("downstream clock pm enable set");
  a_up_ie_zero: assert property (
    (ce_i && upstream_port_i) |=> (!bwie_q && !abie_q))
    else $error("upstream interrupt enable writable");
  a_speed_legal: assert property (
    spd_q >= `SPD_MIN && spd_q <= `SPD_MAX)
    else $error("reported speed out of range");
  a_terr_clear: assert property (
    (ce_i && train_done_i && !train_fail_i) |=> !terr_q)
    else $error("training error not cleared");
  a_trn_clear: assert property (
    (ce_i && !train_start_i && train_done_i) |=> !trn_q)
    else $error("training flag not cleared");
  a_bw_set_wins: assert property (
    (ce_i && bw_mgmt_evt_i) |=> bws_q)
    else $error("bandwidth event lost");
  a_bw_hold: assert property (
    (ce_i && !bw_mgmt_evt_i && !(wr_en && hwdata_i[`BWS_BIT]))
      |=> (bws_q == $past(bws_q)))
    else $error("bandwidth flag changed without cause");
  a_bw_irq_path: assert property (
    (ce_i && abs_q && abie_q) |=> bw_irq_o)
    else $error("autonomous bandwidth interrupt missing");
endmodule

// file: testbench/link_partner_model.sv
// link partner model: trains the port and raises link events
module link_partner_model
(
  input  wire logic       clk_i,
  output logic            start_o,
  output logic            done_o,
  output logic            fail_o,
  output logic            mgmt_o,
  output logic            auto_o,
  output logic            slot_ld_o,
  output logic            slot_v_o,
  output logic            dl_o,
  output logic [3:0]      speed_o,
  output logic [5:0]      width_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] p = '0;
  assign {slot_ld_o, auto_o, mgmt_o, fail_o, done_o, start_o} = p;
  initial
  begin
    slot_v_o = 1'b1;
    dl_o = 1'b0;
    speed_o = 4'h2;
    width_o = 6'h01;
  end
  // one-cycle strobe: 0 start 1 done 2 fail 3 mgmt 4 auto 5 slot load
  task automatic pulse(input int k);
    @(posedge clk_i);
    p[k] <= 1'b1;
    @(posedge clk_i);
    p <= '0;
  endtask
  // train to an outcome at speed s and width w; afterwards the inverted, unsupported speed code is driven
  task automatic train(input logic ok, input logic [3:0] s,
                       input logic [5:0] w);
    speed_o <= s;
    width_o <= w;
    pulse(0);
    repeat (3) @(posedge clk_i);
    pulse(ok ? 1 : 2);
    speed_o <= ~s;
    width_o <= ~w;
  endtask
  task automatic set_dl(input logic v);
    @(posedge clk_i);
    dl_o <= v;
  endtask
  task automatic slot(input logic v);
    slot_v_o <= v;
    pulse(5);
    slot_v_o <= ~v;
  endtask
endmodule

// file: testbench/test_pcie_port_link_ctrl_status.sv
// bench for the port link control and status dword
`include "link_regs_cfg.svh"
module test_pcie_port_link_ctrl_status;
  timeunit 1ns;
  timeprecision 1ps;
  import link_regs_pkg::*;
  logic        clk_i, arst_n_i, hsel, hwrite, up, need, ce;
  logic [2:0]  hsize;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic        hready, hresp, l0s, l1, rx, ldis, rtr, cclk, ckr, wdis, irq;
  logic [12:0] fts, ts1;
  logic        st, dn, fl, mg, au, sld, sv, dl;
  speed_type   spd;
  width_type   wid;
  int          n_errors, total_checks, i;
  pcie_port_link_ctrl_status uut
  (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
    .upstream_port_i(up), .link_speed_i(spd), .link_width_i(wid),
    .train_start_i(st), .train_done_i(dn), .train_fail_i(fl),
    .dl_active_i(dl), .slot_clk_load_i(sld), .slot_clk_val_i(sv),
    .bw_mgmt_evt_i(mg), .bw_auto_evt_i(au), .clk_need_i(need),
    .l0s_en_o(l0s), .l1_en_o(l1), .rx_l0s_ok_o(rx),
    .link_disable_o(ldis), .retrain_o(rtr), .common_clk_o(cclk),
    .fts_count_o(fts), .ts1_count_o(ts1), .clkreq_n_o(ckr),
    .hw_width_dis_o(wdis), .bw_irq_o(irq)
  );
  link_partner_model lp
  (
    .clk_i(clk_i), .start_o(st), .done_o(dn), .fail_o(fl), .mgmt_o(mg),
    .auto_o(au), .slot_ld_o(sld), .slot_v_o(sv), .dl_o(dl),
    .speed_o(spd), .width_o(wid)
  );
  task wrap_up;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("ERROR %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task rdy;
    int k;
    k = 0;
    @(posedge clk_i);
    while (hready !== 1'b1 && k < 50)
    begin
      @(posedge clk_i);
      k++;
    end
    if (k == 50)
    begin
      n_errors++;
      wrap_up;
    end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    r = hrdata;
  endtask
  task rd(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(r, e);
    chk(hresp, 1'b0);
  endtask
  task settle;
    repeat (3) @(posedge clk_i);
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial
  begin
    {arst_n_i, hsel, hwrite, up, need} = '0;
    {htrans, haddr, hwdata, n_errors, total_checks} = '0;
    ce = 1'b1;
    hsize = 3'h2;
    repeat (6) @(posedge clk_i);
    chk({l0s, l1, rx, ldis, rtr, cclk, ckr, wdis, irq}, 9'h040);
    chk({fts, ts1}, {`NRM_FTS, `NRM_TS1});
    arst_n_i <= 1'b1;
    rd(`LNK_OFFSET, 32'h1812_0000);
    $display("test reset done");
    bus(1'b1, `LNK_OFFSET, 32'h0000_FFFF);
    @(posedge clk_i);
    chk(rtr, 1'b1);
    @(posedge clk_i);
    chk(rtr, 1'b0);
    repeat (2) @(posedge clk_i);
    chk({l0s, l1, rx, ldis, cclk, ckr, wdis, irq}, 8'hFA);
    chk({fts, ts1}, {`EXT_FTS, `EXT_TS1});
    rd(`LNK_OFFSET, 32'h1812_0ED3);
    for (i = 0; i < 4; i++)
    begin
      bus(1'b1, `LNK_OFFSET, 32'(i));
      settle;
      chk({l0s, l1, rx}, {i[0], i[1], 1'b1});
    end
    chk(fts, `NRM_FTS);
    $display("test downstream control done");
    up <= 1'b1;
    bus(1'b1, `LNK_OFFSET, 32'h0000_FFFF);
    settle;
    rd(`LNK_OFFSET, 32'h1812_03C3);
    chk(ldis, 1'b0);
    need <= 1'b1;
    settle;
    chk(ckr, 1'b0);
    need <= 1'b0;
    settle;
    chk(ckr, 1'b1);
    bus(1'b1, `LNK_OFFSET, 32'h0);
    settle;
    chk(ckr, 1'b0);
    up <= 1'b0;
    $display("test upstream control done");
    lp.train(1'b0, 4'h2, 6'h04);
    rd(`LNK_OFFSET, 32'h1412_0000);
    lp.pulse(0);
    rd(`LNK_OFFSET, 32'h1C12_0000);
    lp.train(1'b1, 4'h1, 6'h04);
    rd(`LNK_OFFSET, 32'h1041_0000);
    lp.set_dl(1'b1);
    settle;
    rd(`LNK_OFFSET, 32'h3041_0000);
    lp.slot(1'b0);
    rd(`LNK_OFFSET, 32'h2041_0000);
    $display("test training done");
    lp.pulse(3);
    bus(1'b1, `LNK_OFFSET, 32'h0000_0400);
    settle;
    chk(irq, 1'b1);
    rd(`LNK_OFFSET, 32'h6041_0400);
    bus(1'b1, `LNK_OFFSET, 32'h4000_0400);
    settle;
    chk(irq, 1'b0);
    lp.pulse(4);
    bus(1'b1, `LNK_OFFSET, 32'h0000_0800);
    settle;
    chk(irq, 1'b1);
    rd(`LNK_OFFSET, 32'hA041_0800);
    bus(1'b1, `LNK_OFFSET, 32'h8000_0800);
    rd(`LNK_OFFSET, 32'h2041_0800);
    rd(32'h0000_00D4, 32'h0);
    ce <= 1'b0;
    lp.pulse(3);
    ce <= 1'b1;
    rd(`LNK_OFFSET, 32'h2041_0800);
    $display("test bandwidth done");
    wrap_up;
  end
endmodule
